// ==== design/pcb_bank_dec.sv ====
// bank select decode for the banked special and general windows
`timescale 1ns/100ps
module pcb_bank_dec import pcb_pkg::*; (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] bank_select_register,
    input wire logic [7:0] dm_addr,
    input wire logic dm_wr,
    input wire logic [7:0] dm_rd_raw,
    output logic dm_wr_gated,
    output logic [7:0] dm_rd_data,
    output logic bank_missing
);

    logic [3:0] per_bank;
    logic [3:0] ram_bank;
    logic in_per;
    logic in_ram;

    // -----------------------------------------------------------------
    // window decode
    // -----------------------------------------------------------------
    // low nibble picks peripheral bank
    assign per_bank = bank_select_register[BSR_RAM_LSB-1:0];
    assign ram_bank = bank_select_register[7:BSR_RAM_LSB];
    assign in_per = (dm_addr >= PER_WIN_LO) && (dm_addr <= PER_WIN_HI);
    assign in_ram = dm_addr >= RAM_WIN_LO;

    // missing bank reads zero, writes dropped
    always_comb begin
        bank_missing = (in_per && !PER_BANKS_IMPL[per_bank])
            || (in_ram && !RAM_BANKS_IMPL[ram_bank]);
        dm_rd_data = bank_missing ? 8'h00 : dm_rd_raw;
        dm_wr_gated = dm_wr && !bank_missing;
    end

    // decoded again from the raw inputs, so a broken bank_missing shows
    property p_missing_bank;
        @(posedge ref_clk) disable iff (!arst_n)
        (dm_addr >= PER_WIN_LO && dm_addr <= PER_WIN_HI
            && !PER_BANKS_IMPL[bank_select_register[BSR_RAM_LSB-1:0]])
        || (dm_addr >= RAM_WIN_LO
            && !RAM_BANKS_IMPL[bank_select_register[7:BSR_RAM_LSB]])
        |-> bank_missing && (dm_rd_data == 8'h00) && !dm_wr_gated;
    endproperty
    a_missing_bank: assert property (p_missing_bank)
        else $error("missing bank leaks data or write");

endmodule : pcb_bank_dec

// ==== design/pcb_core.sv ====
// program counter, holding latch, bank select and table transfer logic
//
// Behaviour
// - 16-bit counter increments on each fetch unless a branch loads it.
// - skipped instruction runs as a forced no-operation cycle.
// - long call loads high byte from latch, low from opcode.
// - reading counter low byte drives it out, copies high byte to latch.
// - writing counter low byte loads bus value, high byte from latch.
// - read-modify-write on low byte loads result, high byte from latch, latch unchanged.
// - short jump loads low 13 bits, latch gets page and opcode bits.
// - latch unchanged on long call, literal return, interrupt return, vector.
// - low nibble of bank select picks the peripheral bank.
// - high nibble of bank select picks the ram bank.
// - missing bank reads zero and discards writes.
// - latch write loads selected byte of the table latch.
// - table write loads byte, writes latch, increments pointer if asked.
// - table transfers go external only in extended or processor mode.
// - internal table write starts a long write that halts execution.
// - only reset or enabled flagged interrupt ends a long write.
// - pin or timer ending a long write gets its flag cleared.
// - pending interrupt at table write aborts it, clears that flag if pin or timer.
// - peripheral interrupt ending a long write keeps its flag.
// - ending vectors when global disable was clear, else continues.
// - table read outputs latch byte, then reloads latch from memory.
`timescale 1ns/100ps
module pcb_core import pcb_pkg::*; (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic fetch_strobe,
    input wire pcb_op_t op,
    input wire logic [15:0] opcode,
    input wire logic [7:0] data_in,
    input wire logic [15:0] stack_top,
    input wire logic [15:0] vector_addr,
    input wire logic latch_wr,
    input wire logic byte_sel_high,
    input wire logic ptr_inc,
    input wire logic ptr_wr,
    input wire logic [15:0] ptr_wdata,
    input wire logic ext_mode,
    input wire logic [2:0] irq_enable,
    input wire logic [2:0] irq_flag,
    input wire logic periph_pending,
    input wire logic global_interrupt_disable,
    input wire logic [15:0] prog_rdata,
    input wire logic [7:0] dm_addr,
    input wire logic dm_wr,
    input wire logic [7:0] dm_rd_raw,
    output logic [15:0] pc_q,
    output logic [7:0] counter_high_holding_latch_q,
    output logic [7:0] bank_select_register_q,
    output logic [15:0] table_pointer_q,
    output logic [15:0] table_latch_q,
    output logic [7:0] data_out_q,
    output logic [15:0] prog_addr,
    output logic [15:0] prog_wdata,
    output logic prog_we_int,
    output logic prog_we_ext_q,
    output logic prog_re,
    output logic halted,
    output logic forced_nop_q,
    output logic [2:0] flag_clr_q,
    output logic vector_req_q,
    output logic dm_wr_gated,
    output logic [7:0] dm_rd_data,
    output logic bank_missing
);

    pcb_lw_t lw_q, lw_d;
    logic [15:0] pc_d, ptr_d, tlat_d;
    logic [7:0] lat_d, bsr_d, dout_d;
    logic wext_d, nop_d, vreq_d;
    logic [2:0] fclr_d;
    logic [2:0] irq_live;
    logic [2:0] irq_first;
    logic term;
    logic [7:0] tl_byte;

    // -----------------------------------------------------------------
    // interrupt view
    // -----------------------------------------------------------------
    assign irq_live = irq_enable & irq_flag;
    // lowest index is the highest priority source
    assign irq_first = irq_live & ~(irq_live - 3'b001);
    // enabled and flagged source ends the write
    assign term = (|irq_live) || periph_pending;
    assign tl_byte = byte_sel_high ? table_latch_q[15:8] : table_latch_q[7:0];

    assign halted = lw_q != PCB_LW_IDLE;
    assign prog_addr = table_pointer_q;
    assign prog_wdata = table_latch_q;
    // write strobe held for the whole long write
    assign prog_we_int = lw_q == PCB_LW_WRITE;
    assign prog_re = !halted && op == PCB_OP_TABLE_RD;

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        pc_d = pc_q;
        lat_d = counter_high_holding_latch_q;
        bsr_d = bank_select_register_q;
        ptr_d = table_pointer_q;
        tlat_d = table_latch_q;
        dout_d = data_out_q;
        lw_d = lw_q;
        wext_d = 1'b0;
        nop_d = 1'b0;
        vreq_d = 1'b0;
        fclr_d = 3'b000;
        case (lw_q)
            PCB_LW_IDLE: begin
                // software may load the latch directly
                if (latch_wr) begin
                    lat_d = data_in;
                end
                if (ptr_wr) begin
                    ptr_d = ptr_wdata;
                end
                // fetch advances the counter by default
                if (fetch_strobe) begin
                    pc_d = pc_q + 16'h0001;
                end
                case (op)
                    PCB_OP_SHORT_JMP: begin
                        pc_d = {pc_q[15:SHORT_PAGE_LSB],
                                opcode[SHORT_TGT_MSB:0]};
                        lat_d = {pc_q[15:SHORT_PAGE_LSB],
                                 opcode[SHORT_TGT_MSB:SHORT_LAT_LSB]};
                    end
                    PCB_OP_LONG_CALL: begin
                        pc_d = {counter_high_holding_latch_q, opcode[7:0]};
                    end
                    PCB_OP_RETURN: begin
                        lat_d = pc_q[15:8];
                        pc_d = stack_top;
                    end
                    // literal and interrupt returns and vector leave latch alone
                    PCB_OP_RET_LIT, PCB_OP_RET_INT: begin
                        pc_d = stack_top;
                    end
                    PCB_OP_VECTOR: begin
                        pc_d = vector_addr;
                    end
                    // low byte out, high byte to latch
                    PCB_OP_PCL_READ: begin
                        dout_d = pc_q[7:0];
                        lat_d = pc_q[15:8];
                    end
                    PCB_OP_PCL_WRITE: begin
                        pc_d = {counter_high_holding_latch_q, data_in};
                    end
                    // result to low byte, high byte from latch, latch kept
                    PCB_OP_PCL_RMW: begin
                        pc_d = {counter_high_holding_latch_q, data_in};
                    end
                    // skipped word runs as a no-operation
                    PCB_OP_SKIP: begin
                        nop_d = 1'b1;
                    end
                    PCB_OP_LATCH_WR: begin
                        if (byte_sel_high) begin
                            tlat_d[15:8] = data_in;
                        end else begin
                            tlat_d[7:0] = data_in;
                        end
                    end
                    PCB_OP_TABLE_WR: begin
                        if (term) begin
                            nop_d = 1'b1;
                            fclr_d = irq_first;
                        end else begin
                            // load byte then write whole latch
                            if (byte_sel_high) begin
                                tlat_d[15:8] = data_in;
                            end else begin
                                tlat_d[7:0] = data_in;
                            end
                            if (ext_mode) begin
                                wext_d = 1'b1;
                                if (ptr_inc) begin
                                    ptr_d = table_pointer_q + 16'h0001;
                                end
                            end else begin
                                lw_d = PCB_LW_WRITE;
                            end
                        end
                    end
                    // latch byte out, no memory access
                    PCB_OP_LATCH_RD: begin
                        dout_d = tl_byte;
                    end
                    PCB_OP_TABLE_RD: begin
                        dout_d = tl_byte;
                        tlat_d = prog_rdata;
                        if (ptr_inc) begin
                            ptr_d = table_pointer_q + 16'h0001;
                        end
                    end
                    PCB_OP_BANK_LIT: begin
                        if (opcode[8]) begin
                            bsr_d[7:BSR_RAM_LSB] = opcode[3:0];
                        end else begin
                            bsr_d[BSR_RAM_LSB-1:0] = opcode[3:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // counter and pointer frozen while writing
            PCB_LW_WRITE: begin
                // only an enabled flagged source ends it
                if (term) begin
                    lw_d = PCB_LW_END;
                    // pin or timer flag cleared, peripheral kept
                    fclr_d = irq_first;
                    // vector only when global disable clear
                    vreq_d = !global_interrupt_disable;
                end
            end
            PCB_LW_END: begin
                lw_d = PCB_LW_IDLE;
                if (ptr_inc) begin
                    ptr_d = table_pointer_q + 16'h0001;
                end
            end
            default: begin
                lw_d = PCB_LW_IDLE;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_q <= PC_RST;
            counter_high_holding_latch_q <= LATCH_RST;
            bank_select_register_q <= BSR_RST;
            table_pointer_q <= TBL_RST;
            table_latch_q <= TBL_RST;
            data_out_q <= 8'h00;
            lw_q <= PCB_LW_IDLE;
            prog_we_ext_q <= 1'b0;
            forced_nop_q <= 1'b0;
            vector_req_q <= 1'b0;
            flag_clr_q <= 3'b000;
        end else begin
            pc_q <= pc_d;
            counter_high_holding_latch_q <= lat_d;
            bank_select_register_q <= bsr_d;
            table_pointer_q <= ptr_d;
            table_latch_q <= tlat_d;
            data_out_q <= dout_d;
            lw_q <= lw_d;
            prog_we_ext_q <= wext_d;
            forced_nop_q <= nop_d;
            vector_req_q <= vreq_d;
            flag_clr_q <= fclr_d;
        end
    end

    pcb_bank_dec u_bank (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .bank_select_register(bank_select_register_q),
        .dm_addr(dm_addr),
        .dm_wr(dm_wr),
        .dm_rd_raw(dm_rd_raw),
        .dm_wr_gated(dm_wr_gated),
        .dm_rd_data(dm_rd_data),
        .bank_missing(bank_missing)
    );

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence s_issue_int;
        !halted && op == PCB_OP_TABLE_WR && !term && !ext_mode;
    endsequence

    sequence s_halt_hold;
        lw_q == PCB_LW_WRITE && !term;
    endsequence

    property p_fetch_inc;
        @(posedge ref_clk) disable iff (!arst_n)
        !halted && fetch_strobe && !latch_wr && op == PCB_OP_NONE
        |=> pc_q == $past(pc_q) + 16'h0001;
    endproperty
    a_fetch_inc: assert property (p_fetch_inc)
        else $error("counter did not advance on fetch");

    property p_long_call;
        @(posedge ref_clk) disable iff (!arst_n)
        !halted && op == PCB_OP_LONG_CALL && !latch_wr
        |=> pc_q == {$past(counter_high_holding_latch_q), $past(opcode[7:0])}
            && $stable(counter_high_holding_latch_q);
    endproperty
    a_long_call: assert property (p_long_call)
        else $error("long call target or latch wrong");

    property p_pcl_read;
        @(posedge ref_clk) disable iff (!arst_n)
        !halted && op == PCB_OP_PCL_READ
        |=> data_out_q == $past(pc_q[7:0])
            && counter_high_holding_latch_q == $past(pc_q[15:8]);
    endproperty
    a_pcl_read: assert property (p_pcl_read)
        else $error("low byte read mishandled");

    property p_pcl_write;
        @(posedge ref_clk) disable iff (!arst_n)
        !halted && (op == PCB_OP_PCL_WRITE || op == PCB_OP_PCL_RMW)
        |=> pc_q == {$past(counter_high_holding_latch_q), $past(data_in)};
    endproperty
    a_pcl_write: assert property (p_pcl_write)
        else $error("computed jump wrong");

    property p_return;
        @(posedge ref_clk) disable iff (!arst_n)
        !halted && op == PCB_OP_RETURN
        |=> pc_q == $past(stack_top)
            && counter_high_holding_latch_q == $past(pc_q[15:8]);
    endproperty
    a_return: assert property (p_return)
        else $error("return mishandled");

    property p_short_jmp;
        @(posedge ref_clk) disable iff (!arst_n)
        !halted && op == PCB_OP_SHORT_JMP
        |=> pc_q[12:0] == $past(opcode[12:0])
            && counter_high_holding_latch_q
               == {$past(pc_q[15:13]), $past(opcode[12:8])};
    endproperty
    a_short_jmp: assert property (p_short_jmp)
        else $error("short jump mishandled");

    property p_long_write_hold;
        @(posedge ref_clk) disable iff (!arst_n)
        s_issue_int ##1 s_halt_hold
        |=> lw_q == PCB_LW_WRITE && prog_we_int
            && $stable(pc_q) && $stable(table_pointer_q);
    endproperty
    a_long_write_hold: assert property (p_long_write_hold)
        else $error("state moved during long write");

    property p_end_vector;
        @(posedge ref_clk) disable iff (!arst_n)
        lw_q == PCB_LW_WRITE && term
        |=> vector_req_q == !$past(global_interrupt_disable)
            && flag_clr_q == $past(irq_first) ##1 lw_q == PCB_LW_IDLE;
    endproperty
    a_end_vector: assert property (p_end_vector)
        else $error("long write ending wrong");

    property p_abort;
        @(posedge ref_clk) disable iff (!arst_n)
        !halted && op == PCB_OP_TABLE_WR && term
        |=> forced_nop_q && !halted && !prog_we_ext_q
            && flag_clr_q == $past(irq_first);
    endproperty
    a_abort: assert property (p_abort)
        else $error("pending interrupt did not abort write");

    property p_table_read;
        @(posedge ref_clk) disable iff (!arst_n)
        !halted && op == PCB_OP_TABLE_RD
        |=> data_out_q == $past(tl_byte) && table_latch_q == $past(prog_rdata);
    endproperty
    a_table_read: assert property (p_table_read)
        else $error("table read order wrong");

endmodule : pcb_core

// ==== design/pcb_pkg.sv ====
// package: shared constants and types of the counter, bank and table block
package pcb_pkg;

    // -----------------------------------------------------------------
    // widths and reset values
    // -----------------------------------------------------------------
    localparam int PC_W = 16;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] BSR_RST = 8'h00;
    localparam logic [15:0] TBL_RST = 16'h0000;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int SHORT_TGT_MSB = 12;
    localparam int SHORT_PAGE_LSB = 13;
    localparam int SHORT_LAT_LSB = 8;
    localparam int BSR_RAM_LSB = 4;

    // -----------------------------------------------------------------
    // banked windows and implemented banks (one bit per bank)
    // -----------------------------------------------------------------
    localparam logic [7:0] PER_WIN_LO = 8'h10;
    localparam logic [7:0] PER_WIN_HI = 8'h17;
    localparam logic [7:0] RAM_WIN_LO = 8'h20;
    localparam logic [15:0] PER_BANKS_IMPL = 16'h000f;
    localparam logic [15:0] RAM_BANKS_IMPL = 16'h0003;

    // -----------------------------------------------------------------
    // operations from the instruction decoder
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        PCB_OP_NONE = 4'h0,
        PCB_OP_SHORT_JMP = 4'h1,
        PCB_OP_LONG_CALL = 4'h2,
        PCB_OP_RETURN = 4'h3,
        PCB_OP_RET_LIT = 4'h4,
        PCB_OP_RET_INT = 4'h5,
        PCB_OP_VECTOR = 4'h6,
        PCB_OP_PCL_READ = 4'h7,
        PCB_OP_PCL_WRITE = 4'h8,
        PCB_OP_PCL_RMW = 4'h9,
        PCB_OP_SKIP = 4'ha,
        PCB_OP_LATCH_WR = 4'hb,
        PCB_OP_TABLE_WR = 4'hc,
        PCB_OP_LATCH_RD = 4'hd,
        PCB_OP_TABLE_RD = 4'he,
        PCB_OP_BANK_LIT = 4'hf
    } pcb_op_t;

    // long write states, gray along idle -> write -> ending
    typedef enum logic [1:0] {
        PCB_LW_IDLE = 2'b00,
        PCB_LW_WRITE = 2'b01,
        PCB_LW_END = 2'b11
    } pcb_lw_t;

endpackage : pcb_pkg

// ==== dv/pc_bank_table_access_test.sv ====
// self-checking bench for the counter, bank and table block
`timescale 1ns/100ps
module pc_bank_table_access_test import pcb_pkg::*;;
    logic ref_clk = 0, arst_n = 0, fetch_strobe = 0, latch_wr = 0;
    logic byte_sel_high = 0, ptr_inc = 0, ptr_wr = 0, ext_mode = 0;
    logic periph_pending = 0, global_interrupt_disable = 0, dm_wr = 1;
    pcb_op_t op = PCB_OP_NONE;
    logic [15:0] opcode = 0, stack_top = 0, vector_addr = 0, ptr_wdata = 0;
    logic [7:0] data_in = 0, dm_addr = 0, dm_rd_raw = 8'ha5;
    logic [2:0] irq_enable = 0, irq_flag = 0, clr_seen;
    logic [15:0] prog_rdata, pc_q, table_pointer_q, table_latch_q;
    logic [15:0] prog_addr, prog_wdata;
    logic [7:0] counter_high_holding_latch_q, bank_select_register_q;
    logic [7:0] data_out_q, dm_rd_data;
    logic prog_we_int, prog_we_ext_q, prog_re, halted, forced_nop_q;
    logic vector_req_q, dm_wr_gated, bank_missing, vec_seen;
    logic [2:0] flag_clr_q;
    int bad_count = 0, checked = 0;
    pcb_op_t rops[3] = '{PCB_OP_RET_LIT, PCB_OP_RET_INT, PCB_OP_VECTOR};
    logic [15:0] bopc[4] = '{16'h0102, 16'h0101, 16'h0005, 16'h0003};
    logic [7:0] bexp[4] = '{8'h20, 8'h10, 8'h15, 8'h13};

    pcb_core DUT (.ref_clk, .arst_n, .fetch_strobe, .op, .opcode, .data_in,
        .stack_top, .vector_addr, .latch_wr, .byte_sel_high, .ptr_inc,
        .ptr_wr, .ptr_wdata, .ext_mode, .irq_enable, .irq_flag,
        .periph_pending, .global_interrupt_disable, .prog_rdata, .dm_addr,
        .dm_wr, .dm_rd_raw, .pc_q, .counter_high_holding_latch_q,
        .bank_select_register_q, .table_pointer_q, .table_latch_q,
        .data_out_q, .prog_addr, .prog_wdata, .prog_we_int, .prog_we_ext_q,
        .prog_re, .halted, .forced_nop_q, .flag_clr_q, .vector_req_q,
        .dm_wr_gated, .dm_rd_data, .bank_missing);
    pcb_prog_mem u_mem (.ref_clk, .prog_addr, .prog_wdata, .prog_we_int,
        .prog_we_ext_q, .prog_re, .prog_rdata);

    always #50 ref_clk = ~ref_clk;

    // -----------------------------------------------------------------
    // access tasks
    // -----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    // called at a falling edge, returns one cycle later with strobes low
    task automatic step(input pcb_op_t o, input logic [15:0] opc,
            input logic [7:0] d);
        op = o;
        opcode = opc;
        data_in = d;
        @(negedge ref_clk);
        op = PCB_OP_NONE;
        fetch_strobe = 0;
        latch_wr = 0;
        ptr_wr = 0;
    endtask : step
    // pulses are gathered over a window, ending latency left open
    task automatic wait_end();
        clr_seen = 0;
        vec_seen = 0;
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            clr_seen = clr_seen | flag_clr_q;
            vec_seen = vec_seen | vector_req_q;
        end
        irq_flag = 0;
        periph_pending = 0;
    endtask : wait_end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        fork
            begin
                #(3000 * 100);
                bad_count++;
                finish_test();
            end
        join_none
        repeat (16) @(negedge ref_clk);
        arst_n = 1;
        check(pc_q, 16'h0000);
        fetch_strobe = 1;
        step(PCB_OP_NONE, 0, 0);
        check(pc_q, 16'h0001);
        step(PCB_OP_SHORT_JMP, 16'h1abc, 0);
        check(pc_q, 16'h1abc);
        check(counter_high_holding_latch_q, 8'h1a);
        latch_wr = 1;
        step(PCB_OP_NONE, 0, 8'h03);
        step(PCB_OP_PCL_WRITE, 0, 8'h20);
        check(pc_q, 16'h0320);
        step(PCB_OP_LONG_CALL, 16'h0055, 0);
        check(pc_q, 16'h0355);
        check(counter_high_holding_latch_q, 8'h03);
        latch_wr = 1;
        step(PCB_OP_NONE, 0, 8'h44);
        stack_top = 16'h7a10;
        step(PCB_OP_RETURN, 0, 0);
        check(pc_q, 16'h7a10);
        check(counter_high_holding_latch_q, 8'h03);
        step(PCB_OP_PCL_READ, 0, 0);
        check(data_out_q, 8'h10);
        check(counter_high_holding_latch_q, 8'h7a);
        latch_wr = 1;
        step(PCB_OP_NONE, 0, 8'h05);
        step(PCB_OP_PCL_RMW, 0, 8'h40);
        check(pc_q, 16'h0540);
        stack_top = 16'h1234;
        vector_addr = 16'h2468;
        // latch kept on literal and interrupt returns and vector
        foreach (rops[i]) begin
            step(rops[i], 0, 0);
            check(pc_q, i == 2 ? vector_addr : stack_top);
            check(counter_high_holding_latch_q, 8'h05);
        end
        step(PCB_OP_SKIP, 0, 0);
        check(forced_nop_q, 1);
        $display("test counter done");
        for (int i = 0; i < 4; i++) begin
            dm_addr = i < 2 ? 8'h20 : 8'h12;
            step(PCB_OP_BANK_LIT, bopc[i], 0);
            check(bank_select_register_q, bexp[i]);
            check(bank_missing, i % 2 == 0);
            check(dm_rd_data, i % 2 ? 8'ha5 : 8'h00);
            check(dm_wr_gated, i % 2);
        end
        $display("test bank done");
        ptr_wr = 1;
        ptr_wdata = 16'h0040;
        byte_sel_high = 1;
        step(PCB_OP_LATCH_WR, 0, 8'hbe);
        byte_sel_high = 0;
        step(PCB_OP_LATCH_WR, 0, 8'hef);
        check(table_latch_q, 16'hbeef);
        ext_mode = 1;
        ptr_inc = 1;
        step(PCB_OP_TABLE_WR, 0, 8'hed);
        check(prog_we_ext_q, 1);
        check(halted, 0);
        check(table_pointer_q, 16'h0041);
        check(table_latch_q, 16'hbeed);
        ext_mode = 0;
        $display("test external done");
        // one enabled source, then write and verify
        ptr_wr = 1;
        ptr_wdata = 16'h0080;
        byte_sel_high = 1;
        step(PCB_OP_LATCH_WR, 0, 8'h12);
        byte_sel_high = 0;
        ptr_inc = 0;
        irq_enable = 3'b010;
        irq_flag = 3'b001;
        step(PCB_OP_TABLE_WR, 0, 8'h34);
        check(prog_we_int, 1);
        step(PCB_OP_PCL_WRITE, 0, 8'h99);
        check(halted, 1);
        check(pc_q, 16'h2468);
        check(table_pointer_q, 16'h0080);
        irq_flag = 3'b011;
        wait_end();
        check(clr_seen, 3'b010);
        check(vec_seen, 1);
        check(halted, 0);
        step(PCB_OP_TABLE_RD, 0, 0);
        check(data_out_q, 8'h34);
        check(table_latch_q, 16'h1234);
        byte_sel_high = 1;
        step(PCB_OP_LATCH_RD, 0, 0);
        check(data_out_q, 8'h12);
        check(table_pointer_q, 16'h0080);
        $display("test internal done");
        // peripheral ending with global disable set
        global_interrupt_disable = 1;
        irq_enable = 0;
        ptr_inc = 1;
        step(PCB_OP_TABLE_WR, 0, 8'h56);
        check(halted, 1);
        periph_pending = 1;
        wait_end();
        check(clr_seen, 3'b000);
        check(vec_seen, 0);
        check(table_pointer_q, 16'h0081);
        irq_enable = 3'b101;
        irq_flag = 3'b100;
        step(PCB_OP_TABLE_WR, 0, 8'h77);
        check(forced_nop_q, 1);
        check(flag_clr_q, 3'b100);
        check(halted, 0);
        irq_flag = 0;
        step(PCB_OP_TABLE_WR, 0, 8'h78);
        check(halted, 1);
        arst_n = 0;
        @(negedge ref_clk);
        check(halted, 0);
        check(table_pointer_q, TBL_RST);
        arst_n = 1;
        $display("test termination done");
        finish_test();
    end
endmodule : pc_bank_table_access_test

// ==== dv/pcb_prog_mem.sv ====
// program memory model on the far side of the table transfer port
`timescale 1ns/100ps
module pcb_prog_mem (
    input wire logic ref_clk,
    input wire logic [15:0] prog_addr,
    input wire logic [15:0] prog_wdata,
    input wire logic prog_we_int,
    input wire logic prog_we_ext_q,
    input wire logic prog_re,
    output logic [15:0] prog_rdata
);
    // only 256 words modelled, upper address bits ignored
    logic [15:0] mem [0:255];
    logic [15:0] last_addr;
    // not read: inverse of address, so stale data never looks valid
    assign prog_rdata = prog_re ? mem[prog_addr[7:0]] : ~prog_addr;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h5a00 | 16'(i);
        end
    end
    // external write pulse follows the cycle that held the address
    always @(posedge ref_clk) begin
        last_addr <= prog_addr;
        if (prog_we_int) begin
            mem[prog_addr[7:0]] <= prog_wdata;
        end else if (prog_we_ext_q) begin
            mem[last_addr[7:0]] <= prog_wdata;
        end
    end
endmodule : pcb_prog_mem
